// ---- logic/iess_pkg.sv ----
// Purpose: constants and types for the internal error severity select block
// Assumes: one 32-bit severity register, AHB-Lite word access, 250 MHz mclk
// Notes: bits 0-5 and 24-31 of the severity word are handled elsewhere
//
// Behaviour
// - a set severity bit reports its error type as uncorrectable
// - a clear severity bit reports its error type as correctable
// - bit 6 selects severity of egress completion time-out
// - bits 7-10 select ingress data single/double, control single/double severity
// - bits 11-14 select egress data single/double, control single/double severity
// - bit 15 selects path parity severity, bit 16 unreliable link severity
// - bits 17 and 18 select replay control single and double severity
// - bits 19-21 select DMA time-out severity, bit 23 DMA data single
// - DMA bits stay read-write but act only in ports with DMA
// - bits 8,10,12,14,15,18,19 reset to one, other described bits zero
// - severity register sits at byte offset 0x48C
package iess_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] SEV_ADDR = 12'h48C;
    localparam logic [ADDR_W-1:0] STS_ADDR = 12'h4A0;
    localparam logic [ADDR_W-1:0] MSK_ADDR = 12'h4A4;

    // ************************************************************
    // severity word fields
    // ************************************************************
    localparam int EGRESS_CPL_TIMEOUT_SEV = 6;
    localparam int INGRESS_DATA_SINGLE_ERR_SEV = 7;
    localparam int INGRESS_DATA_DOUBLE_ERR_SEV = 8;
    localparam int INGRESS_CTL_SINGLE_ERR_SEV = 9;
    localparam int INGRESS_CTL_DOUBLE_ERR_SEV = 10;
    localparam int EGRESS_DATA_SINGLE_ERR_SEV = 11;
    localparam int EGRESS_DATA_DOUBLE_ERR_SEV = 12;
    localparam int EGRESS_CTL_SINGLE_ERR_SEV = 13;
    localparam int EGRESS_CTL_DOUBLE_ERR_SEV = 14;
    localparam int PATH_PARITY_ERR_SEV = 15;
    localparam int UNRELIABLE_LINK_SEV = 16;
    localparam int REPLAY_CTL_SINGLE_ERR_SEV = 17;
    localparam int REPLAY_CTL_DOUBLE_ERR_SEV = 18;
    localparam int DMA_INGRESS_POSTED_TIMEOUT_SEV = 19;
    localparam int DMA_INGRESS_NONPOSTED_TIMEOUT_SEV = 20;
    localparam int DMA_INGRESS_CPL_TIMEOUT_SEV = 21;
    localparam int SEV_RESERVED_BIT = 22;
    localparam int DMA_INGRESS_DATA_SINGLE_ERR_SEV = 23;
    localparam int NUM_TYPES = 24;

    // described writable bits, DMA subset, reset value
    localparam logic [31:0] SEV_WMASK = 32'h00BFFFC0;
    localparam logic [31:0] SEV_DMA_MASK = 32'h00B80000;
    localparam logic [31:0] SEV_RESET = 32'h000CD500;

    // ************************************************************
    // interrupt status and mask fields
    // ************************************************************
    localparam int STS_W = 2;
    localparam int STS_UNCORR = 0;
    localparam int STS_CORR = 1;
    localparam logic [STS_W-1:0] STS_RESET = 2'h0;
    localparam logic [STS_W-1:0] MSK_RESET = 2'h0;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        REG_NONE,
        REG_SEV,
        REG_STS,
        REG_MSK
    } iess_reg_t;

    typedef struct packed {
        logic [31:0] sev;
        logic [STS_W-1:0] mask;
        logic [STS_W-1:0] status;
        logic wrPend;
        iess_reg_t wrSel;
        logic [31:0] rdata;
        logic uncorr;
        logic corr;
        logic [NUM_TYPES-1:0] uncorrType;
        logic [NUM_TYPES-1:0] corrType;
        logic touched;
    } iess_state_t;

endpackage

// ---- logic/iess_route.sv ----
// Purpose: splits detected internal errors into uncorrectable and correctable
// Assumes: errEvent and sev come from the mclk domain
// Notes: purely combinational, one slice per error type
module iess_route (
    // error sources
    input wire logic [iess_pkg::NUM_TYPES-1:0] errEvent,
    input wire logic dmaPort,
    // severity selection
    input wire logic [31:0] sev,
    // split reports
    output logic [iess_pkg::NUM_TYPES-1:0] uncorrVec,
    output logic [iess_pkg::NUM_TYPES-1:0] corrVec
);

    // ************************************************************
    // per type routing
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < iess_pkg::NUM_TYPES; i++) begin : g_type
            logic live;
            // DMA types count only where a DMA function exists
            assign live = iess_pkg::SEV_WMASK[i] &
                (~iess_pkg::SEV_DMA_MASK[i] | dmaPort);
            assign uncorrVec[i] = errEvent[i] & live & sev[i];
            assign corrVec[i] = errEvent[i] & live & ~sev[i];
        end
    endgenerate

endmodule

// ---- logic/iess_top.sv ----
// Purpose: severity select register with AHB-Lite access and error routing
// Assumes: zero-wait AHB-Lite slave, single word transfers, mclk 250 MHz
// Notes: status bits clear on read, irq is the OR of status bits whose mask bit is set
module iess_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // error sources
    input wire logic [iess_pkg::NUM_TYPES-1:0] errEvent,
    input wire logic dmaPort,
    // error reports
    output logic uncorrErr,
    output logic corrErr,
    output logic [iess_pkg::NUM_TYPES-1:0] uncorrType,
    output logic [iess_pkg::NUM_TYPES-1:0] corrType,
    // interrupt
    output logic irq
);

    iess_pkg::iess_state_t s;
    iess_pkg::iess_state_t next_s;
    logic addrPhase;
    logic rdPhase;
    iess_pkg::iess_reg_t sel;
    logic [iess_pkg::NUM_TYPES-1:0] uncorrVec;
    logic [iess_pkg::NUM_TYPES-1:0] corrVec;

    // ************************************************************
    // error routing
    // ************************************************************
    iess_route u_route (
        .errEvent(errEvent),
        .dmaPort(dmaPort),
        .sev(s.sev),
        .uncorrVec(uncorrVec),
        .corrVec(corrVec)
    );

    // ************************************************************
    // bus decode
    // ************************************************************
    assign addrPhase = hsel & htrans[1] & hready;
    assign rdPhase = addrPhase & ~hwrite;

    always_comb begin
        case (haddr[iess_pkg::ADDR_W-1:0])
            iess_pkg::SEV_ADDR: sel = iess_pkg::REG_SEV;
            iess_pkg::STS_ADDR: sel = iess_pkg::REG_STS;
            iess_pkg::MSK_ADDR: sel = iess_pkg::REG_MSK;
            default: sel = iess_pkg::REG_NONE;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_s = s;
        // write data phase
        if (s.wrPend) begin
            case (s.wrSel)
                iess_pkg::REG_SEV: begin
                    // reserved and out-of-block bits keep zero
                    next_s.sev = (s.sev & ~iess_pkg::SEV_WMASK) |
                        (hwdata & iess_pkg::SEV_WMASK);
                    next_s.touched = 1'b1;
                end
                iess_pkg::REG_MSK: next_s.mask = hwdata[iess_pkg::STS_W-1:0];
                default: next_s.touched = s.touched;
            endcase
        end
        next_s.wrPend = addrPhase & hwrite;
        next_s.wrSel = sel;
        // registered error reports
        next_s.uncorrType = uncorrVec;
        next_s.corrType = corrVec;
        next_s.uncorr = |uncorrVec;
        next_s.corr = |corrVec;
        // sticky status, a new event beats the read clear
        if (rdPhase && sel == iess_pkg::REG_STS) begin
            next_s.status = iess_pkg::STS_RESET;
        end
        next_s.status[iess_pkg::STS_UNCORR] = next_s.status[iess_pkg::STS_UNCORR] |
            (|uncorrVec);
        next_s.status[iess_pkg::STS_CORR] = next_s.status[iess_pkg::STS_CORR] |
            (|corrVec);
        // read data, forwarded past a write in its data phase
        if (rdPhase) begin
            case (sel)
                iess_pkg::REG_SEV: next_s.rdata = next_s.sev & iess_pkg::SEV_WMASK;
                iess_pkg::REG_STS: next_s.rdata = {30'h0, s.status};
                iess_pkg::REG_MSK: next_s.rdata = {30'h0, next_s.mask};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s.sev <= iess_pkg::SEV_RESET;
            s.mask <= iess_pkg::MSK_RESET;
            s.status <= iess_pkg::STS_RESET;
            s.wrPend <= 1'b0;
            s.wrSel <= iess_pkg::REG_NONE;
            s.rdata <= 32'h00000000;
            s.uncorr <= 1'b0;
            s.corr <= 1'b0;
            s.uncorrType <= 24'h000000;
            s.corrType <= 24'h000000;
            s.touched <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign uncorrErr = s.uncorr;
    assign corrErr = s.corr;
    assign uncorrType = s.uncorrType;
    assign corrType = s.corrType;
    assign irq = |(s.status & s.mask);

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_uncorr_report: assert property (
        (|(errEvent & s.sev[iess_pkg::NUM_TYPES-1:0] & iess_pkg::SEV_WMASK[23:0] &
          ~iess_pkg::SEV_DMA_MASK[23:0])) |=> uncorrErr && s.status[iess_pkg::STS_UNCORR])
        else $error("uncorrectable error not reported");

    a_corr_report: assert property (
        (errEvent[iess_pkg::UNRELIABLE_LINK_SEV] && !s.sev[iess_pkg::UNRELIABLE_LINK_SEV])
        |=> corrErr && !uncorrType[iess_pkg::UNRELIABLE_LINK_SEV])
        else $error("correctable error not reported");

    a_cpl_timeout_sev: assert property (
        errEvent[iess_pkg::EGRESS_CPL_TIMEOUT_SEV] |=>
        uncorrType[iess_pkg::EGRESS_CPL_TIMEOUT_SEV] ==
        $past(s.sev[iess_pkg::EGRESS_CPL_TIMEOUT_SEV]) &&
        corrType[iess_pkg::EGRESS_CPL_TIMEOUT_SEV] ==
        !$past(s.sev[iess_pkg::EGRESS_CPL_TIMEOUT_SEV]))
        else $error("completion time-out severity wrong");

    a_ingress_ctl_double: assert property (
        errEvent[iess_pkg::INGRESS_CTL_DOUBLE_ERR_SEV] |=>
        uncorrType[iess_pkg::INGRESS_CTL_DOUBLE_ERR_SEV] ==
        $past(s.sev[iess_pkg::INGRESS_CTL_DOUBLE_ERR_SEV]))
        else $error("ingress control double severity wrong");

    a_egress_data_single: assert property (
        errEvent[iess_pkg::EGRESS_DATA_SINGLE_ERR_SEV] |=>
        corrType[iess_pkg::EGRESS_DATA_SINGLE_ERR_SEV] ==
        !$past(s.sev[iess_pkg::EGRESS_DATA_SINGLE_ERR_SEV]))
        else $error("egress data single severity wrong");

    a_path_parity_sev: assert property (
        errEvent[iess_pkg::PATH_PARITY_ERR_SEV] |=>
        uncorrType[iess_pkg::PATH_PARITY_ERR_SEV] ==
        $past(s.sev[iess_pkg::PATH_PARITY_ERR_SEV]))
        else $error("path parity severity wrong");

    a_replay_double_sev: assert property (
        errEvent[iess_pkg::REPLAY_CTL_DOUBLE_ERR_SEV] |=>
        uncorrType[iess_pkg::REPLAY_CTL_DOUBLE_ERR_SEV] ==
        $past(s.sev[iess_pkg::REPLAY_CTL_DOUBLE_ERR_SEV]))
        else $error("replay double severity wrong");

    a_dma_posted_sev: assert property (
        (errEvent[iess_pkg::DMA_INGRESS_POSTED_TIMEOUT_SEV] && dmaPort) |=>
        uncorrType[iess_pkg::DMA_INGRESS_POSTED_TIMEOUT_SEV] ==
        $past(s.sev[iess_pkg::DMA_INGRESS_POSTED_TIMEOUT_SEV]))
        else $error("dma posted time-out severity wrong");

    a_dma_inert: assert property (
        !dmaPort |=> !uncorrType[iess_pkg::DMA_INGRESS_CPL_TIMEOUT_SEV] &&
        !corrType[iess_pkg::DMA_INGRESS_DATA_SINGLE_ERR_SEV])
        else $error("dma severity acted without dma function");

    a_reset_value: assert property (
        !s.touched |-> s.sev == iess_pkg::SEV_RESET)
        else $error("severity reset value wrong");

    a_sev_write: assert property (
        (addrPhase && hwrite && sel == iess_pkg::REG_SEV) ##1 1'b1 |=>
        (s.sev & iess_pkg::SEV_WMASK) == ($past(hwdata) & iess_pkg::SEV_WMASK))
        else $error("severity write not stored");

    a_reserved_zero: assert property (
        !s.sev[iess_pkg::SEV_RESERVED_BIT] && !hrdata[iess_pkg::SEV_RESERVED_BIT])
        else $error("reserved bit 22 not zero");

    a_irq_level: assert property (
        (uncorrErr && s.mask[iess_pkg::STS_UNCORR]) ||
        (corrErr && s.mask[iess_pkg::STS_CORR]) |-> irq)
        else $error("interrupt not raised");

    a_ingress_data_single: assert property (
        errEvent[iess_pkg::INGRESS_DATA_SINGLE_ERR_SEV] |=>
        corrType[iess_pkg::INGRESS_DATA_SINGLE_ERR_SEV] ==
        !$past(s.sev[iess_pkg::INGRESS_DATA_SINGLE_ERR_SEV]))
        else $error("ingress data single severity wrong");

    a_ingress_data_double: assert property (
        errEvent[iess_pkg::INGRESS_DATA_DOUBLE_ERR_SEV] |=>
        uncorrType[iess_pkg::INGRESS_DATA_DOUBLE_ERR_SEV] ==
        $past(s.sev[iess_pkg::INGRESS_DATA_DOUBLE_ERR_SEV]))
        else $error("ingress data double severity wrong");

    a_ingress_ctl_single: assert property (
        errEvent[iess_pkg::INGRESS_CTL_SINGLE_ERR_SEV] |=>
        corrType[iess_pkg::INGRESS_CTL_SINGLE_ERR_SEV] ==
        !$past(s.sev[iess_pkg::INGRESS_CTL_SINGLE_ERR_SEV]))
        else $error("ingress control single severity wrong");

    a_egress_data_double: assert property (
        errEvent[iess_pkg::EGRESS_DATA_DOUBLE_ERR_SEV] |=>
        uncorrType[iess_pkg::EGRESS_DATA_DOUBLE_ERR_SEV] ==
        $past(s.sev[iess_pkg::EGRESS_DATA_DOUBLE_ERR_SEV]))
        else $error("egress data double severity wrong");

    a_egress_ctl_single: assert property (
        errEvent[iess_pkg::EGRESS_CTL_SINGLE_ERR_SEV] |=>
        corrType[iess_pkg::EGRESS_CTL_SINGLE_ERR_SEV] ==
        !$past(s.sev[iess_pkg::EGRESS_CTL_SINGLE_ERR_SEV]))
        else $error("egress control single severity wrong");

    a_egress_ctl_double: assert property (
        errEvent[iess_pkg::EGRESS_CTL_DOUBLE_ERR_SEV] |=>
        uncorrType[iess_pkg::EGRESS_CTL_DOUBLE_ERR_SEV] ==
        $past(s.sev[iess_pkg::EGRESS_CTL_DOUBLE_ERR_SEV]))
        else $error("egress control double severity wrong");

    a_link_sev: assert property (
        errEvent[iess_pkg::UNRELIABLE_LINK_SEV] |=>
        uncorrType[iess_pkg::UNRELIABLE_LINK_SEV] ==
        $past(s.sev[iess_pkg::UNRELIABLE_LINK_SEV]))
        else $error("unreliable link severity wrong");

    a_replay_single_sev: assert property (
        errEvent[iess_pkg::REPLAY_CTL_SINGLE_ERR_SEV] |=>
        corrType[iess_pkg::REPLAY_CTL_SINGLE_ERR_SEV] ==
        !$past(s.sev[iess_pkg::REPLAY_CTL_SINGLE_ERR_SEV]))
        else $error("replay single severity wrong");

    a_dma_nonposted_sev: assert property (
        errEvent[iess_pkg::DMA_INGRESS_NONPOSTED_TIMEOUT_SEV] && dmaPort |=>
        corrType[iess_pkg::DMA_INGRESS_NONPOSTED_TIMEOUT_SEV] ==
        !$past(s.sev[iess_pkg::DMA_INGRESS_NONPOSTED_TIMEOUT_SEV]))
        else $error("dma non-posted time-out severity wrong");

    a_dma_cpl_sev: assert property (
        errEvent[iess_pkg::DMA_INGRESS_CPL_TIMEOUT_SEV] && dmaPort |=>
        uncorrType[iess_pkg::DMA_INGRESS_CPL_TIMEOUT_SEV] ==
        $past(s.sev[iess_pkg::DMA_INGRESS_CPL_TIMEOUT_SEV]))
        else $error("dma completion time-out severity wrong");

    a_dma_data_single: assert property (
        errEvent[iess_pkg::DMA_INGRESS_DATA_SINGLE_ERR_SEV] && dmaPort |=>
        corrType[iess_pkg::DMA_INGRESS_DATA_SINGLE_ERR_SEV] ==
        !$past(s.sev[iess_pkg::DMA_INGRESS_DATA_SINGLE_ERR_SEV]))
        else $error("dma data single severity wrong");

    a_dma_posted_inert: assert property (
        !dmaPort |=>
        !uncorrType[iess_pkg::DMA_INGRESS_POSTED_TIMEOUT_SEV] &&
        !corrType[iess_pkg::DMA_INGRESS_NONPOSTED_TIMEOUT_SEV])
        else $error("dma time-out acted without dma function");

    a_reserved_silent: assert property (
        errEvent[iess_pkg::SEV_RESERVED_BIT] |=>
        !uncorrType[iess_pkg::SEV_RESERVED_BIT] &&
        !corrType[iess_pkg::SEV_RESERVED_BIT])
        else $error("reserved type reported");

    a_report_quiet: assert property (
        errEvent == 24'h000000 |=>
        !uncorrErr && !corrErr)
        else $error("report without error event");

    a_status_hold: assert property (
        s.status[iess_pkg::STS_UNCORR] && !(rdPhase && sel == iess_pkg::REG_STS) |=>
        s.status[iess_pkg::STS_UNCORR])
        else $error("uncorrectable status lost");

endmodule

// ---- dv/iess_tb.sv ----
// Purpose: self-checking bench for the severity select block
// Assumes: zero-wait AHB-Lite slave, one-cycle error pulses, 250 MHz mclk
// Notes: report pulses are sampled at the falling edge while they stand
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // clock and reset
    logic mclk;
    logic rst_n;
    // bus master side
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    // error side
    logic [23:0] errEvent;
    logic dmaPort;
    logic uncorrErr;
    logic corrErr;
    logic [23:0] uncorrType;
    logic [23:0] corrType;
    logic irq;
    int failCount;
    int checked;
    logic [31:0] rd;

    iess_top iess_top_i (
        .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .errEvent(errEvent),
        .dmaPort(dmaPort), .uncorrErr(uncorrErr), .corrErr(corrErr),
        .uncorrType(uncorrType), .corrType(corrType), .irq(irq)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failCount++;
            stop_test;
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, addr};
        wait_ready;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready;
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic pulse(input int i, input logic [23:0] u, input logic [23:0] c);
        errEvent <= 24'h1 << i;
        @(posedge mclk);
        errEvent <= 24'h0;
        @(negedge mclk);
        check({8'h0, uncorrType}, {8'h0, u});
        check({8'h0, corrType}, {8'h0, c});
        check({30'h0, uncorrErr, corrErr}, {30'h0, |u, |c});
        @(posedge mclk);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic regs_scenario;
        bus(1'b0, iess_pkg::SEV_ADDR, 32'h0);
        check(rd, 32'h000CD500);
        bus(1'b0, iess_pkg::STS_ADDR, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, iess_pkg::MSK_ADDR, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 12'h400, 32'hFFFFFFFF);
        bus(1'b0, 12'h400, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, iess_pkg::SEV_ADDR, 32'hFFFFFFFF);
        bus(1'b0, iess_pkg::SEV_ADDR, 32'h0);
        check(rd, 32'h00BFFFC0);
        bus(1'b1, iess_pkg::SEV_ADDR, 32'h00400000);
        bus(1'b0, iess_pkg::SEV_ADDR, 32'h0);
        check(rd, 32'h0);
    endtask

    task automatic route_scenario(input logic [31:0] sev, input logic dma);
        logic v;
        logic [23:0] u;
        logic [23:0] c;
        dmaPort <= dma;
        bus(1'b1, iess_pkg::SEV_ADDR, sev);
        bus(1'b0, iess_pkg::SEV_ADDR, 32'h0);
        check(rd, sev & 32'h00BFFFC0);
        for (int i = 0; i < 24; i++) begin
            v = iess_pkg::SEV_WMASK[i] && (dma || !iess_pkg::SEV_DMA_MASK[i]);
            u = (v && sev[i]) ? (24'h1 << i) : 24'h0;
            c = (v && !sev[i]) ? (24'h1 << i) : 24'h0;
            pulse(i, u, c);
        end
    endtask

    task automatic irq_scenario;
        dmaPort <= 1'b1;
        bus(1'b0, iess_pkg::STS_ADDR, 32'h0);
        bus(1'b1, iess_pkg::MSK_ADDR, 32'h1);
        bus(1'b1, iess_pkg::SEV_ADDR, 32'h00BFFFC0);
        pulse(8, 24'h000100, 24'h0);
        @(posedge mclk);
        check({31'h0, irq}, 32'h1);
        bus(1'b0, iess_pkg::STS_ADDR, 32'h0);
        check(rd, 32'h1);
        bus(1'b0, iess_pkg::STS_ADDR, 32'h0);
        check(rd, 32'h0);
        @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, iess_pkg::SEV_ADDR, 32'h0);
        pulse(8, 24'h0, 24'h000100);
        @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, iess_pkg::MSK_ADDR, 32'h3);
        @(posedge mclk);
        check({31'h0, irq}, 32'h1);
        bus(1'b0, iess_pkg::STS_ADDR, 32'h0);
        check(rd, 32'h2);
    endtask

    task automatic reset_scenario;
        bus(1'b1, iess_pkg::SEV_ADDR, 32'h0);
        bus(1'b1, iess_pkg::MSK_ADDR, 32'h3);
        rst_n <= 1'b0;
        @(posedge mclk);
        check(hrdata, 32'h0);
        check({31'h0, irq}, 32'h0);
        rst_n <= 1'b1;
        @(posedge mclk);
        bus(1'b0, iess_pkg::SEV_ADDR, 32'h0);
        check(rd, 32'h000CD500);
        bus(1'b0, iess_pkg::MSK_ADDR, 32'h0);
        check(rd, 32'h0);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        failCount = 0;
        checked = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        errEvent = 24'h0;
        dmaPort = 1'b1;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        regs_scenario;
        route_scenario(32'hFFFFFFFF, 1'b1);
        route_scenario(32'h0, 1'b1);
        route_scenario(32'h00555540, 1'b1);
        route_scenario(32'h00AAAA80, 1'b1);
        route_scenario(32'hFFFFFFFF, 1'b0);
        irq_scenario;
        reset_scenario;
        stop_test;
    end
endmodule
